// [rtl/scm_top.sv]
// Purpose: Safe cam window monitor with AXI4-Lite register access
// Assumes: Safe position is sampled synchronously with pos_valid
// Notes:   No fault reaction path exists; only status and outputs change
//
// How it works
// - Continuously check if safe position lies inside window; monitor only.
// - Upper and lower bounds come from separate configuration registers.
// - One status bit per instance, high while position is in window.
// - Leaving the window triggers no fault or stop, only status change.
// - Three independent instances, each with own bounds and status.
// - No activation input; a configured instance stays permanently active.
// - Compared input is the safe position from safe feedback.
// - Status drives a pulsed safe output only when explicitly mapped.
// - Two pulsed outputs may be paired into one dual-channel output.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module scm_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] safe_pos,
	input  wire logic        safe_pos_valid,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [2:0]       in_window_flag,
	output logic [3:0]       pulsed_safe_output,
	output logic             irq
);
	localparam int NI = scm_pkg::NUM_INST;
	localparam int NO = scm_pkg::NUM_OUT;

	typedef struct packed {
		logic                          aw_got;
		logic [7:0]                    aw_addr;
		logic                          w_got;
		logic [31:0]                   w_data;
		logic [3:0]                    w_strb;
		logic                          bvalid;
		logic [1:0]                    bresp;
		logic                          rvalid;
		logic [31:0]                   rdata;
		logic [1:0]                    rresp;
		logic [NI-1:0]                 enable;
		logic [NI-1:0][31:0]           upper;
		logic [NI-1:0][31:0]           lower;
		logic [NO*3-1:0]               outmap;
		logic [1:0]                    pair;
		logic [NI-1:0]                 irq_st;
		logic [NI-1:0]                 irq_msk;
		logic [NI-1:0]                 flag_d;
		logic [31:0]                   pos;
		logic [NI-1:0]                 flag_out;
		logic [NO-1:0]                 out;
		logic                          irq;
		logic [scm_pkg::PCNT_W-1:0]    pcnt;
		logic                          tick;
	} scm_st_t;

	scm_st_t st_reg;
	scm_st_t st_next;

	scm_cfg_if        cfg ();
	logic [NO-1:0]    pulse_drive;
	logic [NO-1:0]    out_req;

	// Byte-lane merge for register writes
	function automatic logic [31:0] scm_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] ws);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (ws[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		scm_merge = r;
	endfunction

	// Bound register index from an address, NI when none matches
	function automatic int scm_bound_idx(input logic [7:0] a,
		input logic [7:0] base);
		scm_bound_idx = NI;
		for (int i = 0; i < NI; i++) begin
			if (a == base + 8'(i * scm_pkg::BOUND_STRIDE)) begin
				scm_bound_idx = i;
			end
		end
	endfunction

	// Configuration toward the comparator core
	assign cfg.enable = st_reg.enable;
	assign cfg.upper  = st_reg.upper;
	assign cfg.lower  = st_reg.lower;

	// Comparator core: only observes position, never commands motion
	scm_window_core u_core (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.pos       (safe_pos),
		.pos_valid (safe_pos_valid),
		.cfg       (cfg.core)
	);

	// Mapping: output o follows its selected instance only when enabled
	always_comb begin
		for (int o = 0; o < NO; o++) begin
			logic [2:0] f;
			f = st_reg.outmap[o*3 +: 3];
			out_req[o] = f[scm_pkg::MAP_EN_BIT] && (f[1:0] < 2'(NI))
				&& cfg.in_window[f[1:0]];
		end
	end

	// Pulsed output drivers sharing one test period
	for (genvar g = 0; g < NO; g++) begin : g_out
		logic req_sel;
		// Paired outputs take the lower output's request for both channels
		assign req_sel = (st_reg.pair[g/2]) ? out_req[g & 2] : out_req[g];
		scm_pulse_out u_po (
			.aclk    (aclk),
			.aresetn (aresetn),
			.req     (req_sel),
			.tick    (st_reg.tick),
			.drive   (pulse_drive[g])
		);
	end

	// Bus, registers, events and output staging
	always_comb begin
		int  wi;
		int  li;
		int  ri;
		int  rli;
		logic [NI-1:0] ev;
		logic [31:0]   rd;
		st_next = st_reg;
		wi  = NI;
		li  = NI;
		ri  = NI;
		rli = NI;
		ev  = '0;
		rd  = scm_pkg::ZERO_WORD;

		// Test pulse period counter
		st_next.tick = 1'b0;
		if (st_reg.pcnt == scm_pkg::PCNT_W'(scm_pkg::PULSE_PERIOD - 1)) begin
			st_next.pcnt = '0;
			st_next.tick = 1'b1;
		end else begin
			st_next.pcnt = st_reg.pcnt + 8'h01;
		end

		// Sample position and flag edges; no stop or fault path is driven
		if (safe_pos_valid) begin
			st_next.pos = safe_pos;
		end
		st_next.flag_d = cfg.in_window;
		ev = cfg.in_window ^ st_reg.flag_d;

		// Write address and data, taken in any order
		if (s_axi_awvalid && !st_reg.aw_got) begin
			st_next.aw_got  = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_reg.w_got) begin
			st_next.w_got  = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end

		// Write commit once both halves are held; readies stay low
		// until the response is taken, so one write at most is open
		if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
			st_next.bvalid = 1'b1;
			st_next.bresp  = scm_pkg::RESP_OKAY;
			wi = scm_bound_idx(st_reg.aw_addr, scm_pkg::OFF_UPPER0);
			li = scm_bound_idx(st_reg.aw_addr, scm_pkg::OFF_LOWER0);
			if (wi < NI) begin
				st_next.upper[wi] = scm_merge(st_reg.upper[wi],
					st_reg.w_data, st_reg.w_strb);
			end else if (li < NI) begin
				st_next.lower[li] = scm_merge(st_reg.lower[li],
					st_reg.w_data, st_reg.w_strb);
			end else begin
				case (st_reg.aw_addr)
					scm_pkg::OFF_CTRL: begin
						if (st_reg.w_strb[0]) begin
							st_next.enable = st_reg.w_data[NI-1:0];
						end
					end
					scm_pkg::OFF_IRQ_ST: begin
						if (st_reg.w_strb[0]) begin
							st_next.irq_st = st_reg.irq_st
								& ~st_reg.w_data[NI-1:0];
						end
					end
					scm_pkg::OFF_IRQ_MSK: begin
						if (st_reg.w_strb[0]) begin
							st_next.irq_msk = st_reg.w_data[NI-1:0];
						end
					end
					scm_pkg::OFF_OUTMAP: begin
						if (st_reg.w_strb[0]) begin
							st_next.outmap[7:0] = st_reg.w_data[7:0];
						end
						if (st_reg.w_strb[1]) begin
							st_next.outmap[NO*3-1:8] =
								st_reg.w_data[NO*3-1:8];
						end
					end
					scm_pkg::OFF_PAIR: begin
						if (st_reg.w_strb[0]) begin
							st_next.pair = st_reg.w_data[1:0];
						end
					end
					scm_pkg::OFF_STATUS, scm_pkg::OFF_POS: begin
						st_next.bresp = scm_pkg::RESP_OKAY; // Read only
					end
					default: begin
						st_next.bresp = scm_pkg::RESP_SLVERR;
					end
				endcase
			end
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
			st_next.aw_got = 1'b0;
			st_next.w_got  = 1'b0;
		end

		// Sticky events: a new event wins over a same-cycle clear
		st_next.irq_st = st_next.irq_st | ev;
		st_next.irq = |(st_next.irq_st & st_next.irq_msk);

		// Read channel
		if (s_axi_arvalid && !st_reg.rvalid) begin
			ri  = scm_bound_idx(s_axi_araddr, scm_pkg::OFF_UPPER0);
			rli = scm_bound_idx(s_axi_araddr, scm_pkg::OFF_LOWER0);
			st_next.rresp = scm_pkg::RESP_OKAY;
			if (ri < NI) begin
				rd = st_reg.upper[ri];
			end else if (rli < NI) begin
				rd = st_reg.lower[rli];
			end else begin
				case (s_axi_araddr)
					scm_pkg::OFF_CTRL:    rd[NI-1:0] = st_reg.enable;
					scm_pkg::OFF_STATUS:  rd[NI-1:0] = cfg.in_window;
					scm_pkg::OFF_IRQ_ST:  rd[NI-1:0] = st_reg.irq_st;
					scm_pkg::OFF_IRQ_MSK: rd[NI-1:0] = st_reg.irq_msk;
					scm_pkg::OFF_OUTMAP:  rd[NO*3-1:0] = st_reg.outmap;
					scm_pkg::OFF_PAIR:    rd[1:0] = st_reg.pair;
					scm_pkg::OFF_POS:     rd = st_reg.pos;
					default: begin
						st_next.rresp = scm_pkg::RESP_SLVERR;
					end
				endcase
			end
			st_next.rvalid = 1'b1;
			st_next.rdata  = rd;
		end else if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end

		// Output staging straight into flops
		st_next.flag_out = cfg.in_window;
		st_next.out      = pulse_drive;
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg       <= '0;
			st_reg.upper <= {NI{scm_pkg::BOUND_RST}};
			st_reg.lower <= {NI{scm_pkg::BOUND_RST}};
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs from flops
	assign s_axi_awready      = !st_reg.aw_got;
	assign s_axi_wready       = !st_reg.w_got;
	assign s_axi_bvalid       = st_reg.bvalid;
	assign s_axi_bresp        = st_reg.bresp;
	assign s_axi_arready      = !st_reg.rvalid;
	assign s_axi_rvalid       = st_reg.rvalid;
	assign s_axi_rdata        = st_reg.rdata;
	assign s_axi_rresp        = st_reg.rresp;
	assign in_window_flag     = st_reg.flag_out;
	assign pulsed_safe_output = st_reg.out;
	assign irq                = st_reg.irq;
endmodule

// [rtl/scm_pkg.sv]
// Purpose: Shared constants and types for the safe cam window monitor
// Assumes: 32-bit signed positions in user units, AXI4-Lite register access
// Notes:   Three monitor instances per axis, all offsets are byte addresses
package scm_pkg;
	localparam int NUM_INST = 3;
	localparam int POS_W    = 32;
	localparam int NUM_OUT  = 4;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL    = 8'h00; // Bit i: instance i configured
	localparam logic [7:0] OFF_STATUS  = 8'h04; // Live in-window flags
	localparam logic [7:0] OFF_IRQ_ST  = 8'h08; // Sticky change events, W1C
	localparam logic [7:0] OFF_IRQ_MSK = 8'h0C; // Event mask
	localparam logic [7:0] OFF_OUTMAP  = 8'h10; // Output routing
	localparam logic [7:0] OFF_PAIR    = 8'h14; // Dual-channel pairing
	localparam logic [7:0] OFF_POS     = 8'h18; // Last safe position, read only
	localparam logic [7:0] OFF_UPPER0  = 8'h20; // Upper bound, stride 8
	localparam logic [7:0] OFF_LOWER0  = 8'h24; // Lower bound, stride 8
	localparam logic [7:0] BOUND_STRIDE = 8'h08;

	// Output map field: 2-bit instance select plus enable per output
	localparam int MAP_FIELD_W = 3;
	localparam int MAP_EN_BIT  = 2;

	// Reset values
	localparam logic [POS_W-1:0] BOUND_RST = 32'h0000_0000;
	localparam logic [31:0]      ZERO_WORD = 32'h0000_0000;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Output test pulse: low for PULSE_LEN cycles every PULSE_PERIOD cycles
	localparam int PULSE_LEN_NS    = 400;
	localparam int PULSE_PERIOD_US = 1;
	localparam int CLK_MHZ         = 125;
	localparam int PULSE_LEN    = (PULSE_LEN_NS * CLK_MHZ + 999) / 1000;
	localparam int PULSE_PERIOD = PULSE_PERIOD_US * CLK_MHZ;
	localparam int PCNT_W       = 8;
endpackage

// [rtl/scm_cfg_if.sv]
// Purpose: Carries configuration from the register file to the monitor core
// Assumes: Single clock domain
// Notes:   Bounds are signed user units
`timescale 1ns/10ps
interface scm_cfg_if;
	logic [scm_pkg::NUM_INST-1:0]                    enable;
	logic signed [scm_pkg::NUM_INST-1:0][scm_pkg::POS_W-1:0] upper;
	logic signed [scm_pkg::NUM_INST-1:0][scm_pkg::POS_W-1:0] lower;
	logic [scm_pkg::NUM_INST-1:0]                    in_window;

	modport regs (output enable, output upper, output lower, input in_window);
	modport core (input enable, input upper, input lower, output in_window);
endinterface

// [rtl/scm_window_core.sv]
// Purpose: Three independent position window comparators
// Assumes: pos_valid marks a fresh safe position sample
// Notes:   Pure monitoring, flags are re-evaluated on each sample
`timescale 1ns/10ps
module scm_window_core (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic signed [31:0]         pos,
	input  wire logic                       pos_valid,
	scm_cfg_if.core                         cfg
);
	typedef struct packed {
		logic [scm_pkg::NUM_INST-1:0] flag;
	} scm_core_st_t;

	scm_core_st_t st_reg;
	scm_core_st_t st_next;

	// Inclusive bound check
	function automatic logic scm_inside(input logic signed [31:0] p,
		input logic signed [31:0] lo, input logic signed [31:0] hi);
		scm_inside = (p >= lo) && (p <= hi);
	endfunction

	// Evaluate each instance on a new sample; unconfigured reads out-of-window
	always_comb begin
		st_next = st_reg;
		for (int i = 0; i < scm_pkg::NUM_INST; i++) begin
			if (!cfg.enable[i]) begin
				st_next.flag[i] = 1'b0;
			end else if (pos_valid) begin
				st_next.flag[i] = scm_inside(pos, cfg.lower[i], cfg.upper[i]);
			end
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign cfg.in_window = st_reg.flag;
endmodule

// [rtl/scm_pulse_out.sv]
// Purpose: Pulsed safe output driver with test pulses
// Assumes: Request level comes from a mapped status bit
// Notes:   A pulse drops the output briefly so the field can be tested
`timescale 1ns/10ps
module scm_pulse_out (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic req,
	input  wire logic tick,
	output logic      drive
);
	typedef struct packed {
		logic [scm_pkg::PCNT_W-1:0] cnt;
		logic                       out;
	} scm_po_st_t;

	scm_po_st_t st_reg;
	scm_po_st_t st_next;

	// Count within the shared period; blank output during the test window
	always_comb begin
		st_next = st_reg;
		if (tick) begin
			st_next.cnt = '0;
		end else begin
			st_next.cnt = st_reg.cnt + 8'h01;
		end
		st_next.out = req &&
			(st_reg.cnt >= scm_pkg::PCNT_W'(scm_pkg::PULSE_LEN));
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign drive = st_reg.out;
endmodule

// [tb/scm_checker.sv]
// Purpose: Port assertions for the safe cam window monitor
// Assumes: One clock, synchronous active-low reset
// Notes:   All pulsed outputs share one test pulse phase
`timescale 1ns/10ps
module scm_checker (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       safe_pos_valid,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic [2:0] in_window_flag,
	input wire logic [3:0] pulsed_safe_output,
	input wire logic       irq
);
	localparam int HI_MAX = 75;
	int hi_cnt;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// High stretch length; a missing test pulse lets it grow
	always_ff @(posedge aclk) begin
		if (!aresetn || pulsed_safe_output == 4'h0)
			hi_cnt <= 0;
		else
			hi_cnt <= hi_cnt + 1;
	end

	// Address and data taken at one edge
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	a_flag_rise_cause: assert property (
		(|(in_window_flag & ~$past(in_window_flag)))
		|-> $past(safe_pos_valid, 2) || $past(safe_pos_valid, 3))
		else $error("flag rose without a position sample");
	a_write_answer: assert property (
		wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_read_block: assert property (
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data pending");
	a_write_block: assert property (
		s_axi_bvalid |-> !s_axi_awready)
		else $error("write address taken while response pending");
	a_pulse_gap: assert property (
		hi_cnt <= HI_MAX)
		else $error("pulsed output missed its test pulse");
	a_out_from_flag: assert property (
		pulsed_safe_output != 4'h0
		|-> in_window_flag != 3'h0 || $past(in_window_flag) != 3'h0)
		else $error("output high with no flag set");
	a_irq_cause: assert property (
		$rose(irq) |-> in_window_flag != $past(in_window_flag)
		|| $past(s_axi_bvalid) || s_axi_bvalid)
		else $error("irq rose without a flag change");
endmodule

bind scm_top scm_checker chk_u (
	.aclk, .aresetn, .safe_pos_valid, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .in_window_flag, .pulsed_safe_output,
	.irq
);

// [tb/scm_feed_model.sv]
// Purpose: Safe position feedback source for the monitor bench
// Assumes: Called just after a rising clock edge
// Notes:   A stale position is replaced by its inverse, then toggles
`timescale 1ns/10ps
module scm_feed_model (
	input  wire logic        aclk,
	output logic      [31:0] safe_pos,
	output logic             safe_pos_valid
);
	initial begin
		safe_pos = 32'h0000_0000;
		safe_pos_valid = 1'b0;
	end

	// One sample a call; gap sets how slowly the feedback answers
	task automatic send(input logic [31:0] p, input int gap);
		@(posedge aclk);
		safe_pos <= p;
		safe_pos_valid <= 1'b1;
		@(posedge aclk);
		safe_pos_valid <= 1'b0;
		safe_pos <= ~p;
		repeat (gap) begin
			@(posedge aclk);
			safe_pos <= ~safe_pos;
		end
	endtask
endmodule

// [tb/tb_safe_cam_position_window.sv]
// Purpose: Register, window, interrupt and output tests
// Assumes: Flags settle two edges after a sample is driven
// Notes:   Responses are always accepted at once
`timescale 1ns/10ps
module tb_safe_cam_position_window;
	logic        aclk;
	logic        aresetn;
	logic [31:0] safe_pos;
	logic        safe_pos_valid;
	logic [7:0]  s_axi_awaddr;
	logic        s_axi_awvalid;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_wvalid;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready;
	logic [7:0]  s_axi_araddr;
	logic        s_axi_arvalid;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready;
	logic [2:0]  in_window_flag;
	logic [3:0]  pulsed_safe_output;
	logic        irq;
	logic [31:0] rd;
	logic [1:0]  rs;
	logic [1:0]  bs;
	logic [2:0]  cur;
	logic [2:0]  ev;
	logic        irq_a;
	logic [3:0]  seen;
	int          err_total;
	int          samples_checked;
	int          lo [3] = '{-100, 0, 200};
	int          up [3] = '{100, 50, 300};
	int          pos [10] = '{-101, -100, 0, 50, 51, 100, 101, 250, 300, 301};

	scm_top dut_u (
		.aclk, .aresetn, .safe_pos, .safe_pos_valid, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.in_window_flag, .pulsed_safe_output, .irq
	);
	scm_feed_model feed_u (.aclk, .safe_pos, .safe_pos_valid);

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Bus master write; bready stays high so the answer is taken at once
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		bs = s_axi_bresp;
		if (n == 20)
			chk("write answer", 32'h1, 32'h0);
		if (n == 20)
			give_verdict();
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		if (n == 20)
			chk("read answer", 32'h1, 32'h0);
		if (n == 20)
			give_verdict();
	endtask

	// Send one sample, then compare flags and status with the bounds
	task automatic samp(input int p, input int gap);
		logic [2:0] nxt;
		feed_u.send(32'(p), gap);
		repeat (3) @(posedge aclk);
		for (int i = 0; i < 3; i++)
			nxt[i] = (p >= lo[i]) && (p <= up[i]);
		chk("in_window_flag", 32'(nxt), 32'(in_window_flag));
		rd_reg(scm_pkg::OFF_STATUS, rd, rs);
		chk("status", 32'(nxt), rd);
		ev = cur ^ nxt;
		cur = nxt;
	endtask

	task automatic seen_hi(output logic [3:0] s);
		s = 4'h0;
		repeat (130) begin
			@(posedge aclk);
			s = s | pulsed_safe_output;
		end
	endtask

	initial begin
		aresetn = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b1;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b1;
		cur = 3'h0;
		err_total = 0;
		samples_checked = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd_reg(scm_pkg::OFF_CTRL, rd, rs);
		chk("ctrl", scm_pkg::ZERO_WORD, rd);
		rd_reg(scm_pkg::OFF_LOWER0, rd, rs);
		chk("lower0", scm_pkg::BOUND_RST, rd);
		rd_reg(8'hFC, rd, rs);
		chk("unmapped", 32'(scm_pkg::RESP_SLVERR), 32'(rs));
		wr(8'hFC, 32'h0000_0000);
		chk("unmapped write", 32'(scm_pkg::RESP_SLVERR), 32'(bs));
		$display("test reset_values done");
		for (int i = 0; i < 3; i++) begin
			wr(scm_pkg::OFF_UPPER0 + 8'(8 * i), 32'(up[i]));
			wr(scm_pkg::OFF_LOWER0 + 8'(8 * i), 32'(lo[i]));
		end
		chk("bound write resp", 32'(scm_pkg::RESP_OKAY), 32'(bs));
		wr(scm_pkg::OFF_CTRL, 32'h0000_0007);
		rd_reg(scm_pkg::OFF_UPPER0 + 8'h10, rd, rs);
		chk("upper2", 32'(up[2]), rd);
		foreach (pos[k])
			samp(pos[k], k % 2);
		$display("test window done");
		wr(scm_pkg::OFF_IRQ_ST, 32'h0000_0007);
		rd_reg(scm_pkg::OFF_IRQ_ST, rd, rs);
		chk("irq_st cleared", scm_pkg::ZERO_WORD, rd);
		samp(0, 0);
		irq_a = irq;
		rd_reg(scm_pkg::OFF_IRQ_ST, rd, rs);
		chk("irq_st", 32'(ev), rd);
		wr(scm_pkg::OFF_IRQ_ST, 32'h0000_0007);
		wr(scm_pkg::OFF_IRQ_MSK, 32'h0000_0007);
		samp(260, 0);
		chk("irq mask", 32'h1, 32'(irq_a ^ irq));
		wr(scm_pkg::OFF_IRQ_ST, 32'h0000_0007);
		rd_reg(scm_pkg::OFF_IRQ_ST, rd, rs);
		chk("irq", 32'h0, 32'(irq));
		$display("test interrupt done");
		wr(scm_pkg::OFF_OUTMAP, 32'h0000_0C44);
		samp(10, 0);
		seen_hi(seen);
		chk("outputs", 32'h1, 32'(seen));
		wr(scm_pkg::OFF_PAIR, 32'h0000_0001);
		seen_hi(seen);
		chk("paired outputs", 32'h3, 32'(seen));
		samp(250, 1);
		rd_reg(scm_pkg::OFF_POS, rd, rs);
		chk("position", 32'h0000_00FA, rd);
		seen_hi(seen);
		chk("outputs moved", 32'h8, 32'(seen));
		$display("test outputs done");
		give_verdict();
	end
endmodule
